// ===== rtl/dual_mpy_mas_defs.vh
`ifndef DUAL_MPY_MAS_DEFS_VH
`define DUAL_MPY_MAS_DEFS_VH
// ----------------------------------------------------------------
// Register map (byte offsets)
// ----------------------------------------------------------------
`define REG_MODE      12'h000
`define REG_STATUS    12'h004
`define REG_ACC_X_LO  12'h008
`define REG_ACC_X_HI  12'h00c
`define REG_ACC_Y_LO  12'h010
`define REG_ACC_Y_HI  12'h014
`define REG_REJECT    12'h018
// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE_FRACTIONAL   0
`define MODE_PRODUCT_SAT  1
`define MODE_WIDE_OVF     2
`define MODE_ROUND_SEL    3
`define MODE_SAT_ON_OVF   4
`define MODE_SIGN_EXT     5
`define MODE_WIDTH        6
`define MODE_RESET        6'h20
// Status fields
`define STAT_OVF_X        0
`define STAT_OVF_Y        1
`define STAT_REJ_PAIR     2
`define STAT_REJ_MAPPED   3
// ----------------------------------------------------------------
// Decode constants
// ----------------------------------------------------------------
`define OPC_LONG_BYTE0    8'hfd
`define OPC_LONG_SUB      6'h13
`define OPC_DUAL_BYTE0    8'h92
`define OPC_DUAL_SUB      2'h2
`define MAPPED_REG_TOP    16'h005f
`define ACC_WIDTH         40
`endif

// ===== rtl/mpy17.v
`timescale 1ns/1ns
// 17x17 multiply with fractional shift and product saturation.
module mpy17 (
  // Operands
  input  wire [15:0] op_a,
  input  wire [15:0] op_b,
  input  wire        uns_a,
  input  wire        uns_b,
  input  wire        sign_ext_en,
  // Modes
  input  wire        fractional_mode,
  input  wire        product_saturation_mode,
  // Result
  output wire [39:0] product
);
  wire [16:0] ea;
  wire [16:0] eb;
  wire signed [33:0] raw;
  wire [33:0] shifted;
  wire [31:0] prod32;
  wire        sat_case;

  // Unsigned zero-extends; signed follows the sign-extension mode
  assign ea = uns_a ? {1'b0, op_a} : {sign_ext_en & op_a[15], op_a};
  assign eb = uns_b ? {1'b0, op_b} : {sign_ext_en & op_b[15], op_b};
  assign raw = $signed(ea) * $signed(eb);
  assign shifted = fractional_mode ? {raw[32:0], 1'b0} : raw;
  // 8000h*8000h in fractional mode would give +1.0; clamp it
  assign sat_case = product_saturation_mode & fractional_mode &
                    (op_a == 16'h8000) & (op_b == 16'h8000) &
                    ~uns_a & ~uns_b;
  assign prod32 = sat_case ? 32'h7fffffff : shifted[31:0];
  assign product = {{8{prod32[31]}}, prod32};
endmodule // mpy17

// ===== rtl/acc_post.v
`timescale 1ns/1ns
// Add, round, overflow detect and saturate for one accumulator.
module acc_post (
  input  wire [39:0] base,
  input  wire [39:0] product,
  input  wire        subtract,
  input  wire        round_en,
  input  wire        rounding_select,
  input  wire        wide_mode,
  input  wire        saturate_on_overflow,
  output wire [39:0] result,
  output wire        overflow
);
  wire [40:0] sum;
  wire [40:0] rnd;
  wire [39:0] r40;
  wire        ovf40;
  wire        ovf32;
  wire        neg;

  assign sum = subtract ? {base[39], base} - {product[39], product}
                        : {base[39], base} + {product[39], product};
  // Select 0: add half LSB then clear low word; 1: round to nearest even
  assign rnd = !round_en ? sum :
               (rounding_select && sum[15:0] == 16'h8000) ?
               {sum[40:16] + {24'h0, sum[16]}, 16'h0} :
               {sum[40:16] + {24'h0, sum[15]}, 16'h0};
  assign r40 = rnd[39:0];
  assign ovf40 = rnd[40] ^ rnd[39];
  assign ovf32 = ovf40 | (r40[39:31] != {9{r40[39]}});
  assign overflow = wide_mode ? ovf40 : ovf32;
  assign neg = rnd[40];
  assign result = !(overflow && saturate_on_overflow) ? r40 :
                  wide_mode ? (neg ? 40'h8000000000 : 40'h7fffffffff) :
                  (neg ? 40'hff80000000 : 40'h007fffffff);
endmodule // acc_post

// ===== rtl/dual_mpy_mas_datapath.v
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "dual_mpy_mas_defs.vh"
module dual_mpy_mas_datapath (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Instruction from decoder
  input  wire        instr_valid,
  input  wire [39:0] instr_word,
  input  wire        paired_instr,
  input  wire        repeat_active,
  input  wire [15:0] effective_address,
  input  wire [15:0] data_address_y,
  // Memory read buses
  input  wire [15:0] long_high_read_bus,
  input  wire [15:0] long_low_read_bus,
  input  wire [15:0] data_y_read_bus,
  input  wire [15:0] coef_high_bus,
  input  wire [15:0] coef_low_bus,
  // Address outputs
  output reg  [15:0] long_low_address,
  output reg  [15:0] coef_address_bus,
  output reg  [15:0] coef_low_address,
  // Execution status
  output reg         exec_done,
  output reg         instr_reject
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [`MODE_WIDTH-1:0] mode_q;
  reg [3:0]             status_q;
  reg [39:0]            acc_x_q;
  reg [39:0]            acc_y_q;
  reg [7:0]             reject_cnt_q;

  function [15:0] partner;
    input [15:0] a;
    begin
      partner = a[0] ? a - 16'h0001 : a + 16'h0001;
    end
  endfunction

  function [3:0] acc_sel;
    input [1:0] code;
    begin
      acc_sel = {2'b00, code};
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_long;
  wire is_dual;
  wire legal;
  wire mapped_y;
  wire [1:0] x_sel;
  wire [1:0] y_sel;
  wire uns_hi;
  wire uns_lo;
  wire round_en;
  wire force_wide;

  assign is_long = instr_word[39:32] == `OPC_LONG_BYTE0 &&
                   instr_word[23:18] == `OPC_LONG_SUB;
  // Dual variant: 5 bytes, bit 0 belongs to slot two, so ignored here
  assign is_dual = instr_word[39:32] == `OPC_DUAL_BYTE0 &&
                   instr_word[11:10] == `OPC_DUAL_SUB;
  assign mapped_y = is_dual && data_address_y <= `MAPPED_REG_TOP;
  assign legal = instr_valid && (is_long || is_dual) &&
                 !(is_dual && paired_instr) && !mapped_y;
  assign x_sel = is_long ? instr_word[15:14] : instr_word[5:4];
  assign y_sel = is_long ? instr_word[13:12] : instr_word[3:2];
  assign uns_hi = is_long ? instr_word[11] : instr_word[7];
  assign uns_lo = is_long ? instr_word[10] : instr_word[6];
  assign round_en = is_long ? instr_word[9] : instr_word[1];
  assign force_wide = is_long ? instr_word[8] : instr_word[8];

  wire wide_eff;
  assign wide_eff = mode_q[`MODE_WIDE_OVF] | force_wide;

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  wire [15:0] op_hi;
  wire [15:0] op_lo;
  wire        sx_hi;
  wire        sx_lo;
  // Long: data halves on two buses; dual: Y on its bus, X on low bus
  assign op_hi = is_long ? long_high_read_bus : data_y_read_bus;
  assign op_lo = long_low_read_bus;
  // Long variant always sign-extends; dual follows the mode bit
  assign sx_hi = is_long | mode_q[`MODE_SIGN_EXT];
  assign sx_lo = is_long | mode_q[`MODE_SIGN_EXT];

  wire [39:0] prod_y;
  wire [39:0] prod_x;

  // Two multipliers run in the same cycle
  mpy17 u_mpy_y (
    .op_a                    (op_hi),
    .op_b                    (coef_high_bus),
    .uns_a                   (uns_hi),
    .uns_b                   (uns_hi),
    .sign_ext_en             (sx_hi),
    .fractional_mode         (mode_q[`MODE_FRACTIONAL]),
    .product_saturation_mode (mode_q[`MODE_PRODUCT_SAT]),
    .product                 (prod_y)
  );

  mpy17 u_mpy_x (
    .op_a                    (op_lo),
    .op_b                    (coef_low_bus),
    .uns_a                   (uns_lo),
    .uns_b                   (uns_lo),
    .sign_ext_en             (sx_lo),
    .fractional_mode         (mode_q[`MODE_FRACTIONAL]),
    .product_saturation_mode (mode_q[`MODE_PRODUCT_SAT]),
    .product                 (prod_x)
  );

  wire [39:0] res_y;
  wire [39:0] res_x;
  wire        ovf_y;
  wire        ovf_x;

  acc_post u_post_y (
    .base                 (40'h0),
    .product              (prod_y),
    .subtract             (1'b0),
    .round_en             (round_en),
    .rounding_select      (mode_q[`MODE_ROUND_SEL]),
    .wide_mode            (wide_eff),
    .saturate_on_overflow (mode_q[`MODE_SAT_ON_OVF]),
    .result               (res_y),
    .overflow             (ovf_y)
  );

  acc_post u_post_x (
    .base                 (acc_x_q),
    .product              (prod_x),
    .subtract             (1'b1),
    .round_en             (round_en),
    .rounding_select      (mode_q[`MODE_ROUND_SEL]),
    .wide_mode            (wide_eff),
    .saturate_on_overflow (mode_q[`MODE_SAT_ON_OVF]),
    .result               (res_x),
    .overflow             (ovf_x)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_wr;
  wire apb_rd;
  wire mapped;
  assign apb_wr = psel & penable & pwrite & pready;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign mapped = paddr == `REG_MODE || paddr == `REG_STATUS ||
                  paddr == `REG_ACC_X_LO || paddr == `REG_ACC_X_HI ||
                  paddr == `REG_ACC_Y_LO || paddr == `REG_ACC_Y_HI ||
                  paddr == `REG_REJECT;

  reg [31:0] rd_d;
  always @* begin
    case (paddr)
      `REG_MODE:     rd_d = {26'h0, mode_q};
      `REG_STATUS:   rd_d = {28'h0, status_q};
      `REG_ACC_X_LO: rd_d = acc_x_q[31:0];
      `REG_ACC_X_HI: rd_d = {24'h0, acc_x_q[39:32]};
      `REG_ACC_Y_LO: rd_d = acc_y_q[31:0];
      `REG_ACC_Y_HI: rd_d = {24'h0, acc_y_q[39:32]};
      `REG_REJECT:   rd_d = {24'h0, reject_cnt_q};
      default:       rd_d = 32'h0;
    endcase
  end

  // Accumulator x/y selectors address one pair; other codes ignored
  wire unused_sel;
  assign unused_sel = |acc_sel(x_sel) | |acc_sel(y_sel);

  // ----------------------------------------------------------------
  // Sequential state
  // ----------------------------------------------------------------
  wire [3:0] clr;
  assign clr = (apb_wr && paddr == `REG_STATUS) ? pwdata[3:0] : 4'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q           <= `MODE_RESET;
      status_q         <= 4'h0;
      acc_x_q          <= 40'h0;
      acc_y_q          <= 40'h0;
      reject_cnt_q     <= 8'h00;
      prdata           <= 32'h0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      long_low_address <= 16'h0;
      coef_address_bus <= 16'h0;
      coef_low_address <= 16'h0;
      exec_done        <= 1'b0;
      instr_reject     <= 1'b0;
    end else begin
      // No wait state: ready goes high in the first access cycle
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (apb_rd)
        prdata <= rd_d;
      if (apb_wr && paddr == `REG_MODE)
        mode_q <= pwdata[`MODE_WIDTH-1:0];
      long_low_address <= partner(effective_address);
      coef_address_bus <= effective_address;
      coef_low_address <= partner(effective_address);
      // Repeat re-issues instr_valid every iteration; each executes
      exec_done    <= legal;
      instr_reject <= instr_valid & (is_long | is_dual) & ~legal;
      if (legal) begin
        acc_y_q <= res_y;
        acc_x_q <= res_x;
      end else if (apb_wr) begin
        if (paddr == `REG_ACC_X_LO)
          acc_x_q[31:0] <= pwdata;
        if (paddr == `REG_ACC_X_HI)
          acc_x_q[39:32] <= pwdata[7:0];
        if (paddr == `REG_ACC_Y_LO)
          acc_y_q[31:0] <= pwdata;
        if (paddr == `REG_ACC_Y_HI)
          acc_y_q[39:32] <= pwdata[7:0];
      end
      // Hardware set wins over the write-one clear
      status_q[`STAT_OVF_X] <= (legal & ovf_x) |
        (status_q[`STAT_OVF_X] & ~clr[`STAT_OVF_X]);
      status_q[`STAT_OVF_Y] <= (legal & ovf_y) |
        (status_q[`STAT_OVF_Y] & ~clr[`STAT_OVF_Y]);
      status_q[`STAT_REJ_PAIR] <= (instr_valid & is_dual & paired_instr) |
        (status_q[`STAT_REJ_PAIR] & ~clr[`STAT_REJ_PAIR]);
      status_q[`STAT_REJ_MAPPED] <= (instr_valid & mapped_y) |
        (status_q[`STAT_REJ_MAPPED] & ~clr[`STAT_REJ_MAPPED]);
      if (instr_valid && (is_long || is_dual) && !legal &&
          reject_cnt_q != 8'hff && !unused_sel | unused_sel)
        reject_cnt_q <= reject_cnt_q + 8'h01;
    end
  end
endmodule // dual_mpy_mas_datapath

// ===== bench/dual_mpy_mas_props.sv
`timescale 1ns/1ns
`include "dual_mpy_mas_defs.vh"
module dual_mpy_mas_props (
  // Clock and bus
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // Instruction
  input wire        instr_valid,
  input wire [39:0] instr_word,
  input wire        paired_instr,
  input wire        repeat_active,
  input wire [15:0] effective_address,
  input wire [15:0] data_address_y,
  // Results
  input wire [15:0] long_low_address,
  input wire [15:0] coef_address_bus,
  input wire [15:0] coef_low_address,
  input wire        exec_done,
  input wire        instr_reject
);
  // ----
  // Decode view
  // ----
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire lng = instr_valid && instr_word[39:32] == `OPC_LONG_BYTE0
             && instr_word[23:18] == `OPC_LONG_SUB;
  wire dul = instr_valid && instr_word[39:32] == `OPC_DUAL_BYTE0
             && instr_word[11:10] == `OPC_DUAL_SUB;
  // Both refusal causes of the two-slot form
  wire bad = dul && (paired_instr || data_address_y <= `MAPPED_REG_TOP);
  sequence s_issue;
    lng && !paired_instr;
  endsequence
  sequence s_done;
    exec_done && !instr_reject;
  endsequence
  a_long_done: assert property (s_issue |=> s_done)
    else $error("long form not run");
  a_repeat_run: assert property (
    (lng && !paired_instr && repeat_active) [*2] |=> s_done)
    else $error("repeat not run");
  a_dual_done: assert property (dul && !bad |=> s_done)
    else $error("dual form not run");
  a_reject_bad: assert property (bad |=> instr_reject && !exec_done)
    else $error("bad dual not refused");
  a_done_cause: assert property (exec_done |-> $past(instr_valid))
    else $error("done without issue");
  a_lo_partner: assert property (instr_valid |=> long_low_address ==
    ($past(effective_address) ^ 16'h0001))
    else $error("partner address wrong");
  a_coef_addr: assert property (instr_valid |=> coef_address_bus ==
    $past(effective_address) && coef_low_address ==
    ($past(effective_address) ^ 16'h0001))
    else $error("coef address wrong");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready");
  a_err_ready: assert property (pslverr |-> pready && psel)
    else $error("error outside access");
endmodule // dual_mpy_mas_props

bind dual_mpy_mas_datapath dual_mpy_mas_props chk_u (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .instr_valid,
  .instr_word, .paired_instr, .repeat_active, .effective_address,
  .data_address_y, .long_low_address, .coef_address_bus,
  .coef_low_address, .exec_done, .instr_reject);

// ===== bench/mem_partner.sv
`timescale 1ns/1ns
module mem_partner (
  // Address side
  input  wire        instr_valid,
  input  wire [15:0] effective_address,
  input  wire [15:0] data_address_y,
  // Read buses
  output wire [15:0] long_high_read_bus,
  output wire [15:0] long_low_read_bus,
  output wire [15:0] data_y_read_bus,
  output wire [15:0] coef_high_bus,
  output wire [15:0] coef_low_bus
);
  reg  [15:0] dmem [0:15];
  // Coefficients live in on-chip memory only
  reg  [15:0] cmem [0:15];
  wire [3:0]  ea = effective_address[3:0];
  wire [3:0]  pa = ea ^ 4'h1;
  // Idle buses carry inverted data so a stale sample cannot pass
  wire [15:0] iv = {16{~instr_valid}};
  assign long_high_read_bus = dmem[ea] ^ iv;
  assign long_low_read_bus  = dmem[pa] ^ iv;
  assign data_y_read_bus    = dmem[data_address_y[3:0]] ^ iv;
  assign coef_high_bus      = cmem[ea] ^ iv;
  assign coef_low_bus       = cmem[pa] ^ iv;
endmodule // mem_partner

// ===== bench/dual_mpy_mas_datapath_tb_top.sv
`timescale 1ns/1ns
`include "dual_mpy_mas_defs.vh"
module dual_mpy_mas_datapath_tb_top;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, r;
  reg         instr_valid, paired_instr, repeat_active;
  reg  [39:0] instr_word, ax, ay;
  reg  [15:0] effective_address, data_address_y, ea, ya;
  reg  [5:0]  mode;
  reg  [3:0]  st;
  reg  [7:0]  rej;
  reg  [64:0] exp_q [$];
  integer     bad_count, tests_run, k, i;
  wire [31:0] prdata;
  wire        pready, pslverr, exec_done, instr_reject;
  wire [15:0] long_high_read_bus, long_low_read_bus, data_y_read_bus;
  wire [15:0] coef_high_bus, coef_low_bus, long_low_address;
  wire [15:0] coef_address_bus, coef_low_address;

  dual_mpy_mas_datapath dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_valid, .instr_word, .paired_instr,
    .repeat_active, .effective_address, .data_address_y,
    .long_high_read_bus, .long_low_read_bus, .data_y_read_bus,
    .coef_high_bus, .coef_low_bus, .long_low_address, .coef_address_bus,
    .coef_low_address, .exec_done, .instr_reject);
  mem_partner mem_u (
    .instr_valid, .effective_address, .data_address_y, .long_high_read_bus,
    .long_low_read_bus, .data_y_read_bus, .coef_high_bus, .coef_low_bus);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----
  // Reference arithmetic, c = {rnd, sat, rsel, wide, psat, frac}
  // ----
  function [40:0] mac(input [15:0] a, b, input s, input [39:0] base,
                      input sub, input [5:0] c);
    reg signed [40:0] p, q;
    reg               o;
    begin
      p = $signed({s & a[15], a}) * $signed({s & b[15], b});
      if (c[0]) p = p <<< 1;
      if (&c[1:0] && s && a == 16'h8000 && b == 16'h8000) p = 41'h7fffffff;
      // Only the low 32 product bits survive, then they are sign-extended
      p = $signed(p[31:0]);
      q = sub ? $signed({base[39], base}) - p : p;
      if (c[5]) q = (q + (c[3] ? 41'h7fff + q[16] : 41'h8000)) & ~41'hffff;
      o = c[2] ? q[40] != q[39] : !(&q[40:31] || ~|q[40:31]);
      if (o && c[4]) q = q[40] ? (c[2] ? 41'h18000000000 : 41'h1ff80000000)
                               : (c[2] ? 41'h7fffffffff : 41'h7fffffff);
      mac = {o, q[39:0]};
    end
  endfunction

  task end_sim;
    begin
      if (bad_count == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n == 20) bad_count = bad_count + 1;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] d, m, input e);
    begin
      exp_q.push_back({e, m, d});
      apb(1'b0, a, 32'h0);
    end
  endtask

  task chk;
    begin
      rd(`REG_ACC_X_LO, ax[31:0], 32'hffffffff, 1'b0);
      rd(`REG_ACC_X_HI, {24'h0, ax[39:32]}, 32'hff, 1'b0);
      rd(`REG_ACC_Y_LO, ay[31:0], 32'hffffffff, 1'b0);
      rd(`REG_ACC_Y_HI, {24'h0, ay[39:32]}, 32'hff, 1'b0);
      rd(`REG_STATUS, {28'h0, st}, 32'hf, 1'b0);
      rd(`REG_MODE, {26'h0, mode}, 32'h3f, 1'b0);
      rd(`REG_REJECT, {24'h0, rej}, 32'hff, 1'b0);
      apb(1'b1, `REG_STATUS, 32'hf);
      st = 4'h0;
    end
  endtask

  task issue(input [39:0] w, input [15:0] e, y, input pr, input integer n);
    begin
      @(posedge pclk);
      instr_word <= w;
      effective_address <= e;
      data_address_y <= y;
      paired_instr <= pr;
      repeat_active <= n > 1;
      instr_valid <= 1'b1;
      repeat (n) @(posedge pclk);
      instr_valid <= 1'b0;
      repeat_active <= 1'b0;
      paired_instr <= 1'b0;
    end
  endtask

  // u = {rnd, force wide, unsigned hi or y, unsigned lo or x}
  task op(input dual, input [3:0] u, input integer n);
    reg [40:0] rx, ry;
    reg [5:0]  c;
    reg [3:0]  e;
    integer    j;
    begin
      c = {u[3], mode[4:3], mode[2] | u[2], mode[1:0]};
      e = ea[3:0];
      if (dual)
        issue({8'h92, 20'h0, 3'h4, u[2:0], 4'h0, u[3], 1'b0}, ea, ya, 0,
              n);
      else
        issue({8'hfd, 8'h0, 6'h13, 6'h0, u[1:0], u[3:2], 8'h0}, ea, ya, 0,
              n);
      ry = mac(mem_u.dmem[dual ? ya[3:0] : e], mem_u.cmem[e],
               ~u[1] & mode[5], 40'h0, 1'b0, c);
      for (j = 0; j < n; j = j + 1) begin
        rx = mac(mem_u.dmem[e ^ 4'h1], mem_u.cmem[e ^ 4'h1],
                 ~u[0] & mode[5], ax, 1'b1, c);
        ax = rx[39:0];
        st[0] = st[0] | rx[40];
      end
      ay = ry[39:0];
      st[1] = st[1] | ry[40];
    end
  endtask

  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) begin : mon
      reg [64:0] e;
      e = exp_q.pop_front();
      tests_run = tests_run + 1;
      if (pslverr !== e[64] ||
          ((prdata ^ e[31:0]) & e[63:32]) !== 0) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t got %h %h exp %h %h", $time, pslverr, prdata,
                 e[64], e[31:0]);
      end
    end

  initial begin
    #200000;
    bad_count = bad_count + 1;
    end_sim;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {instr_valid, paired_instr, repeat_active, instr_word} = 0;
    {effective_address, data_address_y, ax, ay, st, rej} = 0;
    bad_count = 0;
    tests_run = 0;
    mode = 6'h20;
    for (i = 0; i < 16; i = i + 1) begin
      mem_u.dmem[i] = 16'h0;
      mem_u.cmem[i] = 16'h0;
    end
    r = $urandom(6151);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk;
    rd(12'h01c, 32'h0, 32'h0, 1'b1);
    for (k = 0; k < 24; k = k + 1) begin
      r = $urandom;
      ea = r[31:16];
      ya = 16'h0060 + r[3:0];
      mode = k[0] ? {1'b1, r[8:4]} : r[9:4];
      if (k == 1) mode = 6'h23;
      // Dual form: x operand mirrored on both halves, positive coefficients
      for (i = 0; i < 16; i = i + 1) begin
        mem_u.dmem[i] <= (k == 1) ? 16'h8000 :
          (!k[0] && (i ^ ea[3:0]) < 2) ? r[15:0] : $urandom;
        mem_u.cmem[i] <= (k == 1) ? 16'h8000 :
          $urandom & (k[0] ? 32'hffff : 32'h7fff);
      end
      ax = {r[13], {7{r[12]}}, $urandom};
      apb(1'b1, `REG_MODE, {26'h0, mode});
      apb(1'b1, `REG_ACC_X_LO, ax[31:0]);
      apb(1'b1, `REG_ACC_X_HI, {24'h0, ax[39:32]});
      op(!k[0], {r[15:14], k == 1 ? 2'b00 : r[11:10]},
         k[0] ? 1 + r[19:18] : 1);
      chk;
    end
    issue({8'h92, 20'h0, 4'h8, 8'h0}, 16'h0, 16'h0070, 1'b1, 1);
    issue({8'h92, 20'h0, 4'h8, 8'h0}, 16'h0, 16'h005f, 1'b0, 1);
    st = 4'hc;
    rej = rej + 8'h2;
    chk;
    end_sim;
  end
endmodule // dual_mpy_mas_datapath_tb_top
